// ===== dv/dbl_bank2_cfg_assertions.sv
// Checker bound to the bank-two configuration block
`timescale 1ns/1ps
module dbl_bank2_chk #(
  parameter int SETTLE_CYCLES = 4  // Unused here, kept in step with design
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [3:0] rotary_pos,
  input wire logic       frame_sync_fitted,
  input wire logic       std_625,
  input wire logic       field_two,
  input wire logic       second_bank_indicator,
  input wire logic       lock_to_reference,
  input wire logic [7:0] pic_offset,
  input wire logic [7:0] h_delay,
  input wire logic       freeze_auto,
  input wire logic       freeze_on,
  input wire logic [1:0] picture_start_sel,
  input wire logic [8:0] picture_start_line,
  input wire logic       vbi_delete,
  input wire logic       vbi_setup,
  input wire logic       super_black
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Knob crossing zero in either direction
  sequence wrap;
    ($past(rotary_pos) == 4'hF && rotary_pos == 4'h0) ||
    ($past(rotary_pos) == 4'h0 && rotary_pos == 4'hF);
  endsequence
  // Adjustments move one step or stay at a limit
  property one_step(logic [7:0] v);
    $changed(v) |-> (8'(v - $past(v)) inside {8'h01, 8'hFF});
  endproperty
  // Six settled samples cover the input sync latency
  property start_at(logic s, logic f, logic [8:0] b);
    (std_625 == s && field_two == f && $stable(picture_start_sel))[*6]
      |-> picture_start_line == b + picture_start_sel;
  endproperty
  chk_bank_wrap: assert property (wrap |-> ##[1:6]
    $changed(second_bank_indicator)) else $error("bank not toggled");
  chk_lock_masked: assert property (
    (!frame_sync_fitted)[*6] |-> !lock_to_reference)
    else $error("lock active without option");
  chk_freeze_masked: assert property (
    (!frame_sync_fitted)[*6] |-> !(freeze_auto || freeze_on))
    else $error("freeze active without option");
  chk_offset_step: assert property (one_step(pic_offset))
    else $error("offset moved more than one step");
  chk_hdelay_step: assert property (one_step(h_delay))
    else $error("delay moved more than one step");
  chk_start_first: assert property (start_at(1'b0, 1'b0, 9'h015))
    else $error("wrong start line 525 field 1");
  chk_start_second: assert property (start_at(1'b1, 1'b1, 9'h151))
    else $error("wrong start line 625 field 2");
  chk_setup_gated: assert property (
    vbi_delete && $past(vbi_delete) |-> !vbi_setup)
    else $error("setup shown while deleting");
  chk_super_blk_gate: assert property (std_625[*6] |-> !super_black)
    else $error("super black in 625 mode");
endmodule : dbl_bank2_chk

bind dbl_bank2_cfg dbl_bank2_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rstn(rstn), .rotary_pos(rotary_pos),
  .frame_sync_fitted(frame_sync_fitted), .std_625(std_625),
  .field_two(field_two), .second_bank_indicator(second_bank_indicator),
  .lock_to_reference(lock_to_reference), .pic_offset(pic_offset),
  .h_delay(h_delay), .freeze_auto(freeze_auto), .freeze_on(freeze_on),
  .picture_start_sel(picture_start_sel),
  .picture_start_line(picture_start_line), .vbi_delete(vbi_delete),
  .vbi_setup(vbi_setup), .super_black(super_black));

// ===== dv/dbl_operator.sv
// Operator model: rotary function switch and paddle
`timescale 1ns/1ps
module dbl_operator (
  input  wire logic       sys_clk,
  output logic      [3:0] rotary_pos,
  output logic            pad_up,
  output logic            pad_dn
);
  // Park on the inactive spot, paddle centred
  initial begin
    rotary_pos = 4'hB;
    pad_up     = 1'b0;
    pad_dn     = 1'b0;
  end
  // Turn the knob, then let the pin sync settle
  task automatic turn(input logic [3:0] p);
    @(posedge sys_clk) #1 rotary_pos = p;
    repeat (8) @(posedge sys_clk);
  endtask : turn
  // Held far past settle time, so a repeat would show
  task automatic flick(input logic up);
    @(posedge sys_clk) #1 {pad_up, pad_dn} = {up, !up};
    repeat (30) @(posedge sys_clk);
    #1 {pad_up, pad_dn} = 2'h0;  // Release both before the next
    repeat (20) @(posedge sys_clk);
  endtask : flick
endmodule : dbl_operator

// ===== dv/testbench.sv
// Self-checking bench for the bank-two configuration block
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, rstn, jumper, fitted, std_625, field_two;
  logic        clk_en;                     // Run enable, dropped once
  logic  [3:0] rotary_pos;
  logic        pad_up, pad_dn, bank2, remote_en, lock_ref;
  logic        frz_auto, frz_on, frz_fld, frz_f2, frz_blk;
  logic  [7:0] pic_ofs, h_del, v_del;
  logic  [1:0] st_sel;
  logic  [8:0] st_line;
  logic        vbi_del, vbi_setup, sblk;
  logic [34:0] snap;                       // Settings before ignored moves
  int          fails, cmp_count;
  // Own table of field start lines: 525 f1/f2, 625 f1/f2
  logic  [8:0] base [4] = '{9'h015, 9'h11C, 9'h018, 9'h151};
  // Every bank-two setting in one word
  wire  [34:0] cfg = {lock_ref, frz_auto, frz_on, frz_fld, frz_f2, frz_blk,
                      pic_ofs, h_del, v_del, st_sel, vbi_del, vbi_setup, sblk};

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  dbl_operator op_u (.sys_clk(sys_clk), .rotary_pos(rotary_pos),
    .pad_up(pad_up), .pad_dn(pad_dn));

  dbl_bank2_cfg #(.SETTLE_CYCLES(4)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .rotary_pos(rotary_pos),
    .paddle_switch_up(pad_up), .paddle_switch_down(pad_dn),
    .remote_access_jumper(jumper), .frame_sync_fitted(fitted),
    .std_625(std_625), .field_two(field_two),
    .second_bank_indicator(bank2), .remote_enable(remote_en),
    .lock_to_reference(lock_ref), .pic_offset(pic_ofs), .h_delay(h_del),
    .v_delay(v_del), .freeze_auto(frz_auto), .freeze_on(frz_on),
    .freeze_field_mode(frz_fld), .freeze_field_two(frz_f2),
    .freeze_black(frz_blk), .picture_start_sel(st_sel),
    .picture_start_line(st_line), .vbi_delete(vbi_del),
    .vbi_setup(vbi_setup), .super_black(sblk));

  // Compare and count
  // Wide enough for the indicator plus every setting
  task automatic check(input string nm, input logic [35:0] seen,
                       input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Select a function and move the paddle once
  task automatic set(input logic [3:0] p, input logic up);
    op_u.turn(p);
    op_u.flick(up);
  endtask : set

  // Lets the synced level inputs land
  task automatic level(input logic f, input logic s, input logic j);
    @(posedge sys_clk) #1 {fitted, std_625, jumper} = {f, s, j};
    repeat (6) @(posedge sys_clk);
  endtask : level

  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    give_verdict();
  end

  initial begin
    {rstn, std_625, field_two} = 3'h0;
    {fitted, jumper}           = 2'h3;
    clk_en = 1'b1;
    fails = 0;
    cmp_count = 0;
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge sys_clk);
    check("reset", {bank2, cfg}, 0);
    set(4'h1, 1'b1);
    check("bank one", pic_ofs, 8'h00);
    op_u.turn(4'hF);
    op_u.turn(4'h0);
    check("bank two", bank2, 1'b1);
    set(4'h0, 1'b0);
    check("lock ref", lock_ref, 1'b1);
    set(4'h0, 1'b1);
    check("lock video", lock_ref, 1'b0);
    set(4'h1, 1'b1);
    set(4'h1, 1'b1);
    check("offset up", pic_ofs, 8'h02);
    set(4'h1, 1'b0);
    check("offset down", pic_ofs, 8'h01);
    // Frozen clock enable must swallow a whole actuation
    @(posedge sys_clk) #1 clk_en = 1'b0;
    set(4'h1, 1'b1);
    check("frozen", pic_ofs, 8'h01);
    @(posedge sys_clk) #1 clk_en = 1'b1;
    repeat (8) @(posedge sys_clk);
    check("thawed", pic_ofs, 8'h01);
    set(4'h2, 1'b0);
    check("h delay", h_del, 8'hFF);
    set(4'h3, 1'b1);
    check("v delay", v_del, 8'h01);
    set(4'h4, 1'b0);
    check("frz auto", frz_auto, 1'b1);
    set(4'h5, 1'b0);
    check("frz on", frz_on, 1'b1);
    set(4'h4, 1'b1);
    check("frz manual", frz_auto, 1'b0);
    set(4'h6, 1'b0);
    set(4'h7, 1'b0);
    set(4'h8, 1'b0);
    check("frz cfg", {frz_fld, frz_f2, frz_blk}, 3'h7);
    snap = cfg;
    set(4'hB, 1'b1);
    set(4'hB, 1'b0);
    op_u.turn(4'hE);
    set(4'hF, 1'b1);
    set(4'hF, 1'b0);
    check("unused", cfg, snap);
    level(1'b0, 1'b0, 1'b1);
    check("frz masked", frz_on, 1'b0);
    set(4'h3, 1'b0);
    set(4'h0, 1'b0);
    check("v no option", v_del, 8'h01);
    level(1'b1, 1'b0, 1'b1);
    check("lock refused", {lock_ref, frz_on}, 2'h1);
    // Every start setting in every standard and field
    for (int s = 0; s < 4; s++) begin
      set(s[1] ? 4'h9 : 4'hA, s[0]);
      check("start sel", st_sel, s[1:0]);
      for (int m = 0; m < 4; m++) begin
        @(posedge sys_clk) #1 {std_625, field_two} = m[1:0];
        repeat (6) @(posedge sys_clk);
        check("start line", st_line, 9'(base[m] + s));
      end
    end
    set(4'hC, 1'b0);
    check("vbi delete", vbi_del, 1'b1);
    set(4'hD, 1'b1);
    set(4'hC, 1'b1);
    check("vbi notch", {vbi_del, vbi_setup}, 2'h0);
    set(4'hD, 1'b1);
    check("setup on", vbi_setup, 1'b1);
    set(4'hD, 1'b0);
    check("setup off", vbi_setup, 1'b0);
    set(4'hE, 1'b1);
    level(1'b1, 1'b0, 1'b0);
    check("sblk 625", sblk, 1'b0);
    check("remote off", remote_en, 1'b0);
    set(4'hE, 1'b1);
    check("sblk on", sblk, 1'b1);
    set(4'hE, 1'b0);
    check("sblk off", sblk, 1'b0);
    level(1'b1, 1'b0, 1'b1);
    check("remote on", remote_en, 1'b1);
    op_u.turn(4'h0);
    op_u.turn(4'hF);
    set(4'h1, 1'b1);
    check("back to one", {bank2, pic_ofs}, 9'h001);
    give_verdict();
  end
endmodule : testbench

// ===== hdl/dbl_bank2_cfg.sv
// Second-bank local configuration interpreter for the video decoder
//
// Contract
// - Position 0: up video, down reference lock
// - Position 1: up advances, down delays offset
// - Positions 2,3 adjust H/V delay, sync option
// - Lock and freeze need sync option fitted
// - Position 4 recognition, 5 manual freeze
// - Positions 6,7,8: mode, field, freeze signal
// - Positions 9 and A pick start setting
// - 525: start lines 21-24 and 284-287
// - 625: start lines 24-27 and 337-340
// - Position C: notch decode or delete lines
// - Position D setup only under notch decode
// - Position E super black, 525 only
// - Revolution past zero toggles bank, indicator
`timescale 1ns/1ps
module dbl_bank2_cfg #(
  parameter int SETTLE_CYCLES = dbl_pkg::SETTLE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       clk_en,              // Freezes all state when low
  input  wire logic [3:0] rotary_pos,          // Function switch pins
  input  wire logic       paddle_switch_up,    // Paddle up contact
  input  wire logic       paddle_switch_down,  // Paddle down contact
  input  wire logic       remote_access_jumper,// High: local and remote
  input  wire logic       frame_sync_fitted,   // Sync option present
  input  wire logic       std_625,             // Line standard, 1 = 625
  input  wire logic       field_two,           // Field being output
  output logic            second_bank_indicator,
  output logic            remote_enable,       // Remote requests accepted
  output logic            lock_to_reference,   // 0 video input, 1 ref
  output logic [7:0]      pic_offset,          // Signed H picture offset
  output logic [7:0]      h_delay,             // Signed H output delay
  output logic [7:0]      v_delay,             // Signed V output delay
  output logic            freeze_auto,         // Recognition automatic
  output logic            freeze_on,           // Manual freeze active
  output logic            freeze_field_mode,   // 1 field, 0 frame
  output logic            freeze_field_two,    // Frozen field is field 2
  output logic            freeze_black,        // Black out during freeze
  output logic [1:0]      picture_start_sel,   // 0..3 = setting one..four
  output logic [8:0]      picture_start_line,  // Start line for field
  output logic            vbi_delete,          // 1 delete, 0 notch decode
  output logic            vbi_setup,           // Setup on data lines
  output logic            super_black          // Pass levels below blank
);

  // Whole register state in one record
  typedef struct packed {
    logic [3:0] pos_s1;     // Synchroniser stage one
    logic [3:0] pos_s2;     // Synchroniser stage two
    logic [3:0] pos_prev;   // Position a cycle ago
    logic [1:0] pad_s1;
    logic [1:0] pad_s2;
    logic [3:0] misc_s1;    // Jumper, option, std, field
    logic [3:0] misc_s2;
    logic       bank2;
    logic       lock_ref;
    logic [7:0] ofs;
    logic [7:0] hdl;
    logic [7:0] vdl;
    logic       frz_auto;
    logic       frz_on;
    logic       frz_field;
    logic       frz_f2;
    logic       frz_black;
    logic [1:0] start_sel;
    logic [8:0] start_line;
    logic       vbi_del;
    logic       vbi_set;
    logic       sblack;
  } dbl_state_type;

  dbl_state_type s_q, s_d;
  logic          up_p;       // One-shot up actuation
  logic          dn_p;       // One-shot down actuation
  logic          jumper_s;
  logic          fitted_s;
  logic          is625_s;
  logic          f2_s;

  assign jumper_s = s_q.misc_s2[3];
  assign fitted_s = s_q.misc_s2[2];
  assign is625_s  = s_q.misc_s2[1];
  assign f2_s     = s_q.misc_s2[0];

  // Saturating signed step, shared by all adjustments
  function automatic logic [7:0] dbl_step(input logic [7:0] v,
                                          input logic       up,
                                          input logic       dn);
    logic [7:0] r;
    r = v;
    if (up && (v != dbl_pkg::ADJ_MAX)) begin
      r = v + dbl_pkg::ADJ_ONE;
    end else if (dn && (v != dbl_pkg::ADJ_MIN)) begin
      r = v - dbl_pkg::ADJ_ONE;
    end
    return r;
  endfunction : dbl_step

  // Start line from setting, field and standard
  function automatic logic [8:0] dbl_start(input logic [1:0] sel,
                                           input logic       is625,
                                           input logic       f2);
    logic [8:0] base;
    base = is625 ? (f2 ? dbl_pkg::START_625_F2 : dbl_pkg::START_625_F1)
                 : (f2 ? dbl_pkg::START_525_F2 : dbl_pkg::START_525_F1);
    return base + {7'h00, sel};
  endfunction : dbl_start

  // Paddle one-shots from the synchronised contacts
  dbl_paddle #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_paddle (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .up_raw     (s_q.pad_s2[1]),
    .down_raw   (s_q.pad_s2[0]),
    .up_pulse   (up_p),
    .down_pulse (dn_p)
  );

  // Next-state logic
  always_comb begin
    s_d          = s_q;
    s_d.pos_s1   = rotary_pos;
    s_d.pos_s2   = s_q.pos_s1;
    s_d.pos_prev = s_q.pos_s2;
    s_d.pad_s1   = {paddle_switch_up, paddle_switch_down};
    s_d.pad_s2   = s_q.pad_s1;
    s_d.misc_s1  = {remote_access_jumper, frame_sync_fitted,
                    std_625, field_two};
    s_d.misc_s2  = s_q.misc_s1;

    // Wrap through zero either way toggles bank
    if ((s_q.pos_prev == dbl_pkg::POS_LAST &&
         s_q.pos_s2 == dbl_pkg::POS_ZERO) ||
        (s_q.pos_prev == dbl_pkg::POS_ZERO &&
         s_q.pos_s2 == dbl_pkg::POS_LAST)) begin
      s_d.bank2 = !s_q.bank2;
    end

    // Actuations only act in the second bank
    if (s_q.bank2 && (up_p || dn_p)) begin
      case (s_q.pos_s2)
        dbl_pkg::POS_LOCK: begin
          // Without the sync option the setting is not taken
          if (fitted_s) begin
            s_d.lock_ref = dn_p;
          end
        end
        dbl_pkg::POS_PIC_OFS: begin
          s_d.ofs = dbl_step(s_q.ofs, up_p, dn_p);
        end
        dbl_pkg::POS_H_DELAY: begin
          if (fitted_s) begin
            s_d.hdl = dbl_step(s_q.hdl, up_p, dn_p);
          end
        end
        dbl_pkg::POS_V_DELAY: begin
          if (fitted_s) begin
            s_d.vdl = dbl_step(s_q.vdl, up_p, dn_p);
          end
        end
        dbl_pkg::POS_FRZ_RECOG: begin
          if (fitted_s) begin
            s_d.frz_auto = dn_p;
          end
        end
        dbl_pkg::POS_FRZ_MAN: begin
          if (fitted_s) begin
            s_d.frz_on = dn_p;
          end
        end
        dbl_pkg::POS_FRZ_MODE: begin
          if (fitted_s) begin
            s_d.frz_field = dn_p;
          end
        end
        dbl_pkg::POS_FRZ_FIELD: begin
          if (fitted_s) begin
            s_d.frz_f2 = dn_p;
          end
        end
        dbl_pkg::POS_FRZ_SIG: begin
          if (fitted_s) begin
            s_d.frz_black = dn_p;
          end
        end
        dbl_pkg::POS_START_HI: begin
          s_d.start_sel = up_p ? 2'h3 : 2'h2;
        end
        dbl_pkg::POS_START_LO: begin
          s_d.start_sel = up_p ? 2'h1 : 2'h0;
        end
        dbl_pkg::POS_VBI_MODE: begin
          s_d.vbi_del = dn_p;
        end
        dbl_pkg::POS_VBI_SETUP: begin
          // Only meaningful while notch decoding
          if (!s_q.vbi_del) begin
            s_d.vbi_set = up_p;
          end
        end
        dbl_pkg::POS_SUPERBLK: begin
          // Ignored in 625 mode
          if (!is625_s) begin
            s_d.sblack = up_p;
          end
        end
        default: begin
          s_d = s_d;
        end
      endcase
    end

    s_d.start_line = dbl_start(s_q.start_sel, is625_s, f2_s);
  end

  // Registers, frozen by clock enable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs from flops; lock, freeze_auto, freeze_on, setup and super black are gated by other flops
  assign second_bank_indicator = s_q.bank2;
  assign remote_enable         = jumper_s;
  assign lock_to_reference     = s_q.lock_ref & fitted_s;
  assign pic_offset            = s_q.ofs;
  assign h_delay               = s_q.hdl;
  assign v_delay               = s_q.vdl;
  assign freeze_auto           = s_q.frz_auto & fitted_s;
  assign freeze_on             = s_q.frz_on & fitted_s;
  assign freeze_field_mode     = s_q.frz_field;
  assign freeze_field_two      = s_q.frz_f2;
  assign freeze_black          = s_q.frz_black;
  assign picture_start_sel     = s_q.start_sel;
  assign picture_start_line    = s_q.start_line;
  assign vbi_delete            = s_q.vbi_del;
  assign vbi_setup             = s_q.vbi_set & !s_q.vbi_del;
  assign super_black           = s_q.sblack & !is625_s;

endmodule : dbl_bank2_cfg

// ===== hdl/dbl_paddle.sv
// Paddle debouncer that yields one pulse per actuation
`timescale 1ns/1ps
module dbl_paddle #(
  parameter int SETTLE_CYCLES = dbl_pkg::SETTLE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic up_raw,      // Synchronised paddle up contact
  input  wire logic down_raw,    // Synchronised paddle down contact
  output logic      up_pulse,    // One pulse per up actuation
  output logic      down_pulse   // One pulse per down actuation
);

  typedef struct packed {
    dbl_pkg::dbl_db_state_type st;
    logic                      dir_up;  // Direction seen at press
    logic [dbl_pkg::DB_W-1:0]  cnt;     // Settle counter
    logic                      up_p;
    logic                      dn_p;
  } dbl_db_type;

  dbl_db_type s_q, s_d;
  logic       any_dir;
  logic [dbl_pkg::DB_W-1:0] settle_last;

  assign any_dir     = up_raw ^ down_raw;
  assign settle_last = dbl_pkg::DB_W'(SETTLE_CYCLES - 1);

  // Next state: press must stay stable for the settle time
  always_comb begin
    s_d      = s_q;
    s_d.up_p = 1'b0;
    s_d.dn_p = 1'b0;
    case (s_q.st)
      dbl_pkg::DBL_IDLE: begin
        if (any_dir) begin
          s_d.st     = dbl_pkg::DBL_SETTLE;
          s_d.dir_up = up_raw;
          s_d.cnt    = '0;
        end
      end
      dbl_pkg::DBL_SETTLE: begin
        // Bounce or direction change restarts from idle
        if (!any_dir || (up_raw != s_q.dir_up)) begin
          s_d.st = dbl_pkg::DBL_IDLE;
        end else if (s_q.cnt == settle_last) begin
          s_d.st   = dbl_pkg::DBL_HELD;
          s_d.up_p = s_q.dir_up;
          s_d.dn_p = !s_q.dir_up;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      dbl_pkg::DBL_HELD: begin
        // No repeat while held; wait for release
        if (!up_raw && !down_raw) begin
          s_d.st = dbl_pkg::DBL_IDLE;
        end
      end
      default: s_d.st = dbl_pkg::DBL_IDLE;
    endcase
  end

  // State register, frozen by the clock enable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: dbl_pkg::DBL_IDLE, dir_up: 1'b0, cnt: '0,
               up_p: 1'b0, dn_p: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign up_pulse   = s_q.up_p & clk_en;
  assign down_pulse = s_q.dn_p & clk_en;

endmodule : dbl_paddle

// ===== shared/dbl_pkg.sv
// Package of constants and types for the bank-two local configuration block
package dbl_pkg;

  // Rotary switch positions of the second bank
  localparam logic [3:0] POS_LOCK      = 4'h0;
  localparam logic [3:0] POS_PIC_OFS   = 4'h1;
  localparam logic [3:0] POS_H_DELAY   = 4'h2;
  localparam logic [3:0] POS_V_DELAY   = 4'h3;
  localparam logic [3:0] POS_FRZ_RECOG = 4'h4;
  localparam logic [3:0] POS_FRZ_MAN   = 4'h5;
  localparam logic [3:0] POS_FRZ_MODE  = 4'h6;
  localparam logic [3:0] POS_FRZ_FIELD = 4'h7;
  localparam logic [3:0] POS_FRZ_SIG   = 4'h8;
  localparam logic [3:0] POS_START_HI  = 4'h9;
  localparam logic [3:0] POS_START_LO  = 4'hA;
  localparam logic [3:0] POS_VBI_MODE  = 4'hC;
  localparam logic [3:0] POS_VBI_SETUP = 4'hD;
  localparam logic [3:0] POS_SUPERBLK  = 4'hE;
  localparam logic [3:0] POS_ZERO      = 4'h0;
  localparam logic [3:0] POS_LAST      = 4'hF;

  // Adjustment widths and limits (signed steps)
  localparam int           ADJ_W   = 8;
  localparam logic [7:0]   ADJ_MAX = 8'h7F;
  localparam logic [7:0]   ADJ_MIN = 8'h80;
  localparam logic [7:0]   ADJ_RST = 8'h00;
  localparam logic [7:0]   ADJ_ONE = 8'h01;

  // Picture start settings: index 0..3 means setting one..four
  localparam logic [1:0]   START_RST = 2'h0;
  localparam logic [8:0]   START_525_F1 = 9'h015;  // Line 21
  localparam logic [8:0]   START_525_F2 = 9'h11C;  // Line 284
  localparam logic [8:0]   START_625_F1 = 9'h018;  // Line 24
  localparam logic [8:0]   START_625_F2 = 9'h151;  // Line 337

  // Paddle debounce: settle time and derived cycles at 50 MHz
  localparam int           CLK_HZ       = 50_000_000;
  localparam int           SETTLE_MS    = 10;
  localparam int           SETTLE_CYC   = CLK_HZ / 1000 * SETTLE_MS;
  localparam int           DB_W         = 20;

  // Paddle debouncer states
  typedef enum logic [1:0] {
    DBL_IDLE,
    DBL_SETTLE,
    DBL_HELD
  } dbl_db_state_type;

endpackage : dbl_pkg
